// *** common/sei_pkg.sv ***
// Constants, types and helpers of the serial EEPROM slave interface
package sei_pkg;

  localparam int ADDR_W     = 11;
  localparam int DATA_W     = 8;
  localparam int PAGE_W     = 5;
  localparam int PAGE_BYTES = 32;
  localparam int TIMER_W    = 20;

  localparam logic [3:0]        BYTE_BITS    = 4'h8;
  localparam logic [ADDR_W-1:0] REG_ADDR     = 11'h7ff;
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 11'h600;
  localparam logic [ADDR_W-1:0] HALF_BASE    = 11'h400;

  // Slave address byte layout
  localparam int SA_SEL_HI  = 7;
  localparam int SA_SEL_MID = 6;
  localparam int SA_SEL_LO  = 5;
  localparam int SA_UP_MSB  = 4;
  localparam int SA_UP_LSB  = 2;
  localparam int SA_TYPE    = 1;
  localparam int SA_RW      = 0;
  // Device type bit of the slave address, value arbitrary
  localparam logic DEV_TYPE_BIT = 1'b1;

  // Protection register layout and command patterns
  localparam int PR_WEL    = 1;
  localparam int PR_RWEL   = 2;
  localparam int PR_BP_LSB = 3;
  localparam int PR_BP_MSB = 4;
  localparam int PR_HWEN   = 7;
  localparam logic [7:0] PR_CLEAR      = 8'h00;
  localparam logic [7:0] PR_LATCH_MASK = 8'hfe;
  localparam logic [7:0] PR_WEL_VAL    = 8'h02;
  localparam logic [7:0] PR_RWEL_VAL   = 8'h06;
  localparam logic [7:0] PR_NV_MASK    = 8'h67;
  localparam logic [7:0] PR_NV_VAL     = 8'h02;

  localparam logic [1:0] BP_NONE    = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;

  // Self-timed write cycle
  localparam int CLK_MHZ          = 100;
  localparam int WRITE_TIME_MS    = 5;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_MS * 1000 * CLK_MHZ;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_DEVADR = 5'b00010,
    ST_WADDR  = 5'b00100,
    ST_WDATA  = 5'b01000,
    ST_READ   = 5'b10000
  } sei_state_t;

  function automatic logic sei_block_protected(input logic [1:0]        bp,
                                               input logic [ADDR_W-1:0] a);
    case (bp)
      BP_NONE:    sei_block_protected = 1'b0;
      BP_QUARTER: sei_block_protected = (a >= QUARTER_BASE);
      BP_HALF:    sei_block_protected = (a >= HALF_BASE);
      default:    sei_block_protected = 1'b1;
    endcase
  endfunction

endpackage

// *** common/sei_nvm_if.sv ***
// Carrier between the bus engine and the storage engine
`timescale 1ns/1ns
`default_nettype none
interface sei_nvm_if;
  import sei_pkg::*;
  logic [PAGE_BYTES-1:0][DATA_W-1:0] pbuf;
  logic [PAGE_BYTES-1:0]             pvalid;
  logic [ADDR_W-1:0]                 base;
  logic                              pend_tog;
  logic [ADDR_W-1:0]                 rd_addr;
  logic                              rd_reg;
  logic [DATA_W-1:0]                 rd_data;
  logic                              busy;
  logic                              write_enable_latch_bit;
  modport link (output pbuf, pvalid, base, pend_tog, rd_addr, rd_reg,
                input  rd_data, busy, write_enable_latch_bit);
  modport nvm  (input  pbuf, pvalid, base, pend_tog, rd_addr, rd_reg,
                output rd_data, busy, write_enable_latch_bit);
endinterface
`default_nettype wire

// *** hw/sei_nvm.sv ***
// Storage engine: stop detection, protection register, timed array write
`timescale 1ns/1ns
`default_nettype none
module sei_nvm import sei_pkg::*; #(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic sys_ce,
  input  wire logic scl,
  input  wire logic sda_in,
  input  wire logic wp_pin,
  sei_nvm_if.nvm    bus
);

  typedef struct packed {
    logic [1:0]         scl_s;
    logic [2:0]         sda_s;
    logic [1:0]         wp_s;
    logic [1:0]         tog_s;
    logic               ack_tog;
    logic               busy;
    logic               copy;
    logic [TIMER_W-1:0] timer;
    logic               write_enable_latch_bit;
    logic               rwel;
    logic [1:0]         bp;
    logic               hwen;
  } sei_nvm_t;

  sei_nvm_t q;
  sei_nvm_t next_q;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic              stop;
  logic              commit;
  logic              hw_lock;
  logic [DATA_W-1:0] d;
  logic [PAGE_W-1:0] idx;
  logic [ADDR_W-1:0] waddr;

  assign stop    = q.scl_s[1] && q.sda_s[1] && !q.sda_s[2];
  assign commit  = stop && (q.tog_s[1] != q.ack_tog) && !q.busy;
  assign hw_lock = q.wp_s[1] && q.hwen;
  assign d       = bus.pbuf[REG_ADDR[PAGE_W-1:0]];
  assign idx     = q.timer[PAGE_W-1:0];
  assign waddr   = {bus.base[ADDR_W-1:PAGE_W], idx};

  always_comb begin
    next_q = q;
    next_q.scl_s = {q.scl_s[0], scl};
    next_q.sda_s = {q.sda_s[1:0], sda_in};
    next_q.wp_s  = {q.wp_s[0], wp_pin};
    next_q.tog_s = {q.tog_s[0], bus.pend_tog};
    if (commit) begin
      next_q.ack_tog = q.tog_s[1];
      if (bus.base == REG_ADDR) begin
        if (d == PR_CLEAR) begin
          next_q.write_enable_latch_bit  = 1'b0;
          next_q.rwel = 1'b0;
        end else if (q.rwel && (d & PR_NV_MASK) == PR_NV_VAL) begin
          // Locked part keeps its settings and the latch stays armed
          if (!hw_lock) begin
            next_q.bp    = d[PR_BP_MSB:PR_BP_LSB];
            next_q.hwen  = d[PR_HWEN];
            next_q.rwel  = 1'b0;
            next_q.busy  = 1'b1;
            next_q.timer = '0;
          end
        end else if (q.write_enable_latch_bit && (d & PR_LATCH_MASK) == PR_RWEL_VAL) begin
          next_q.rwel = 1'b1;
        end else if ((d & PR_LATCH_MASK) == PR_WEL_VAL) begin
          next_q.write_enable_latch_bit = 1'b1;
        end
      end else if (q.write_enable_latch_bit) begin
        next_q.busy  = 1'b1;
        next_q.copy  = 1'b1;
        next_q.timer = '0;
      end
    end
    if (q.busy) begin
      if (q.timer == TIMER_W'(WRITE_CYCLES - 1)) begin
        next_q.busy = 1'b0;
        next_q.copy = 1'b0;
      end else begin
        next_q.timer = q.timer + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // Lines idle high, so no false stop follows reset
      q <= '{scl_s: '1, sda_s: '1, default: '0};
    end else if (sys_ce) begin
      q <= next_q;
    end
  end

  // Page lands in the array during the first cycles of the write time
  always_ff @(posedge sys_clk) begin
    if (sys_ce && q.copy && q.timer < TIMER_W'(PAGE_BYTES) &&
        bus.pvalid[idx] && !sei_block_protected(q.bp, waddr)) begin
      mem[waddr] <= bus.pbuf[idx];
    end
  end

  // Array only changes while the bus engine refuses all requests
  assign bus.rd_data = bus.rd_reg ?
    {q.hwen, 2'b00, q.bp, q.rwel, q.write_enable_latch_bit, 1'b0} : mem[bus.rd_addr];
  assign bus.busy = q.busy;
  assign bus.write_enable_latch_bit  = q.write_enable_latch_bit;

  AST_WRITE_TIME: assert property (@(posedge sys_clk) disable iff (!rstn)
    sys_ce && q.busy && q.timer == TIMER_W'(WRITE_CYCLES - 1)
    |=> !q.busy) else $error("write cycle did not end on time");

endmodule
`default_nettype wire

// *** hw/sei_eeprom.sv ***
// Two-wire slave interface of a 2048 x 8 serial EEPROM
//
// Notes on behaviour
// - SDA changes only while SCL is low
// - Slave only, never drives the clock
// - Ignore the bus until a start
// - Stop ends transaction, returns to standby
// - Release after eight bits, ack ninth
// - Acknowledge address only on own match
// - Selected for write: ack each byte; data acked only with the latch set or as first byte to 7FFh
// - Read: release, sample ack, send next
// - No ack after read: stop transmitting
// - Three address bits match select pins
// - Inverted select pin expects inverted bit
// - Three address bits extend array address
// - Last address bit selects read/write
// - Word address then data, both acked; data only with the latch set or as first byte to 7FFh
// - Stop after data starts the write
// - Busy writing: ignore, no address ack
// - Self-timed write of about 5 ms
// - Protection register at address 7FFh
// - No write until write latch set
// - Block bits protect none, quarter, half, all
// - Protect pin low: only software protection
// - Pin high and enabled: refuse protected writes
// - Latch set by 0000001x to 7FFh
// - Page writes wrap the five low bits
`timescale 1ns/1ns
`default_nettype none
module sei_eeprom import sei_pkg::*; #(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic sys_ce,
  input  wire logic scl,
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe,
  input  wire logic select_pin_low,
  input  wire logic select_pin_mid_inverted,
  input  wire logic select_pin_high,
  input  wire logic wp_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the bus engine, clocked by the serial clock

  typedef struct packed {
    sei_state_t                        st;
    logic [3:0]                        cnt;
    logic [DATA_W-1:0]                 sh;
    logic                              start_seen;
    logic                              stop_seen;
    logic                              ack;
    logic [ADDR_W-1:0]                 addr;
    logic [DATA_W-1:0]                 tx;
    logic [2:0]                        upper;
    logic                              first;
    logic [PAGE_BYTES-1:0][DATA_W-1:0] pbuf;
    logic [PAGE_BYTES-1:0]             pvalid;
    logic [ADDR_W-1:0]                 base;
    logic                              pend_tog;
    logic [2:0]                        sel_s1;
    logic [2:0]                        sel_s2;
    logic [1:0]                        busy_s;
    logic [1:0]                        wel_s;
  } sei_link_t;

  // Values caught on the falling edge of the serial clock
  typedef struct packed {
    logic drive;
  } sei_fall_t;

  sei_link_t         q;
  sei_link_t         next_q;
  sei_fall_t         f;
  sei_fall_t         next_f;
  sei_nvm_if         nvm_bus ();
  logic [DATA_W-1:0] nbyte;
  logic              start;
  logic              stop;
  logic              rx_state;
  logic              busy_l;
  logic              wel_l;
  logic              addr_ok;
  logic              start_tog;
  logic              stop_tog;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Compare a received slave address byte with the strapped select pins
  function automatic logic sei_addr_match(input logic [DATA_W-1:0] b,
                                          input logic [2:0]        sel);
    sei_addr_match = (b[SA_SEL_HI] == sel[2]) &&
                     (b[SA_SEL_MID] == ~sel[1]) &&
                     (b[SA_SEL_LO] == sel[0]) &&
                     (b[SA_TYPE] == DEV_TYPE_BIT);
  endfunction

  function automatic logic [ADDR_W-1:0] sei_page_inc(
      input logic [ADDR_W-1:0] a);
    sei_page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Condition decode

  // A stop and the next start may share one high phase of SCL, which the
  // SCL edges alone cannot see, so flops clocked by SDA flag them
  always_ff @(negedge sda_in or negedge rstn) begin
    if (!rstn) begin
      start_tog <= 1'b0;
    end else if (scl) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge sda_in or negedge rstn) begin
    if (!rstn) begin
      stop_tog <= 1'b0;
    end else if (scl) begin
      stop_tog <= ~stop_tog;
    end
  end

  // Toggles settle a half period before the rising edge that reads them
  assign start    = start_tog != q.start_seen;
  assign stop     = stop_tog != q.stop_seen;
  assign nbyte    = {q.sh[DATA_W-2:0], sda_in};
  assign rx_state = (q.st == ST_DEVADR) || (q.st == ST_WADDR) ||
                    (q.st == ST_WDATA);
  assign busy_l   = q.busy_s[1];
  assign wel_l    = q.wel_s[1];
  assign addr_ok  = sei_addr_match(nbyte, q.sel_s2) && !busy_l;

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine, rising edge

  always_comb begin
    next_q = q;
    next_q.start_seen = start_tog;
    next_q.stop_seen  = stop_tog;
    next_q.sel_s1   = {select_pin_high, select_pin_mid_inverted,
                       select_pin_low};
    next_q.sel_s2   = q.sel_s1;
    next_q.busy_s   = {q.busy_s[0], nvm_bus.busy};
    next_q.wel_s    = {q.wel_s[0], nvm_bus.write_enable_latch_bit};
    if (start) begin
      next_q.st  = ST_DEVADR;
      next_q.cnt = 4'h1;
      next_q.sh  = nbyte;
      next_q.ack = 1'b0;
    end else if (stop) begin
      next_q.st  = ST_IDLE;
      next_q.cnt = 4'h0;
      next_q.ack = 1'b0;
    end else begin
      case (q.st)
        ST_DEVADR, ST_WADDR, ST_WDATA: begin
          if (q.cnt != BYTE_BITS) begin
            next_q.sh  = nbyte;
            next_q.cnt = q.cnt + 1'b1;
            if (q.cnt == BYTE_BITS - 1'b1) begin
              case (q.st)
                ST_DEVADR: begin
                  next_q.ack   = addr_ok;
                  next_q.upper = nbyte[SA_UP_MSB:SA_UP_LSB];
                  if (nbyte[SA_RW]) begin
                    next_q.addr = {nbyte[SA_UP_MSB:SA_UP_LSB],
                                   q.addr[DATA_W-1:0]};
                  end
                end
                ST_WADDR: begin
                  next_q.ack    = 1'b1;
                  next_q.addr   = {q.upper, nbyte};
                  next_q.base   = {q.upper, nbyte};
                  next_q.pvalid = '0;
                  next_q.first  = 1'b1;
                end
                default: begin
                  // Data byte: latch must be set unless it is the first byte to 7FFh
                  next_q.ack = wel_l ||
                    (q.first && q.base == REG_ADDR);
                  if (wel_l || (q.first && q.base == REG_ADDR)) begin
                    next_q.pbuf[q.addr[PAGE_W-1:0]]   = nbyte;
                    next_q.pvalid[q.addr[PAGE_W-1:0]] = 1'b1;
                    next_q.addr  = sei_page_inc(q.addr);
                    next_q.first = 1'b0;
                    if (q.first) begin
                      next_q.pend_tog = ~q.pend_tog;
                    end
                  end
                end
              endcase
            end
          end else begin
            // Acknowledge slot
            next_q.cnt = 4'h0;
            next_q.ack = 1'b0;
            if (!q.ack) begin
              next_q.st = ST_IDLE;
            end else begin
              case (q.st)
                ST_DEVADR: begin
                  if (q.sh[SA_RW]) begin
                    next_q.st = ST_READ;
                    next_q.tx = nvm_bus.rd_data;
                  end else begin
                    next_q.st = ST_WADDR;
                  end
                end
                ST_WADDR: next_q.st = ST_WDATA;
                default:  next_q.st = ST_WDATA;
              endcase
            end
          end
        end
        ST_READ: begin
          if (q.cnt != BYTE_BITS) begin
            next_q.cnt = q.cnt + 1'b1;
            next_q.tx  = {q.tx[DATA_W-2:0], 1'b1};
          end else begin
            next_q.cnt = 4'h0;
            if (sda_in) begin
              next_q.st = ST_IDLE;
            end else begin
              next_q.addr = q.addr + 1'b1;
              next_q.tx   = nvm_bus.rd_data;
            end
          end
        end
        default: begin
          next_q.cnt = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      q <= '{st: ST_IDLE, default: '0};
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine, falling edge: the only place SDA drive changes

  always_comb begin
    next_f = f;
    next_f.drive    = (rx_state && q.cnt == BYTE_BITS && q.ack) ||
                      (q.st == ST_READ && q.cnt != BYTE_BITS &&
                       !q.tx[DATA_W-1]);
  end

  always_ff @(negedge scl or negedge rstn) begin
    if (!rstn) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // Open drain: the pin is only ever pulled low, and SCL is never driven
  assign sda_out = 1'b0;
  assign sda_oe  = f.drive;

  ////////////////////////////////////////////////////////////////////////////
  // Storage engine

  assign nvm_bus.pbuf     = q.pbuf;
  assign nvm_bus.pvalid   = q.pvalid;
  assign nvm_bus.base     = q.base;
  assign nvm_bus.pend_tog = q.pend_tog;
  assign nvm_bus.rd_addr  = (q.st == ST_READ) ? q.addr + 1'b1 : q.addr;
  assign nvm_bus.rd_reg   = (q.st == ST_DEVADR) && (q.addr == REG_ADDR);

  sei_nvm #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_nvm (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sys_ce  (sys_ce),
    .scl     (scl),
    .sda_in  (sda_in),
    .wp_pin  (wp_pin),
    .bus     (nvm_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_START_RESYNC: assert property (@(posedge scl) disable iff (!rstn)
    start |=> q.st == ST_DEVADR && q.cnt == 4'h1)
    else $error("start did not restart address reception");

  AST_STOP_IDLE: assert property (@(posedge scl) disable iff (!rstn)
    stop && !start |=> q.st == ST_IDLE && !q.ack)
    else $error("stop did not return to standby");

  AST_ACK_DRIVEN: assert property (@(posedge scl) disable iff (!rstn)
    rx_state && q.cnt == BYTE_BITS && q.ack |-> sda_oe)
    else $error("acknowledge not driven in ninth clock");

  AST_READ_RELEASE: assert property (@(posedge scl) disable iff (!rstn)
    q.st == ST_READ && q.cnt == BYTE_BITS |-> !sda_oe)
    else $error("transmitter kept SDA in acknowledge slot");

  AST_NO_FOREIGN_ACK: assert property (@(posedge scl) disable iff (!rstn)
    !start && !stop && q.st == ST_DEVADR && q.cnt == 4'h7 &&
    !sei_addr_match(nbyte, q.sel_s2)
    |=> !q.ack ##1 q.st == ST_IDLE)
    else $error("acknowledged a foreign address");

  AST_BUSY_SILENT: assert property (@(posedge scl) disable iff (!rstn)
    !start && !stop && q.st == ST_DEVADR && q.cnt == 4'h7 && busy_l
    |=> !q.ack)
    else $error("acknowledged during write cycle");

  AST_DIRECTION: assert property (@(posedge scl) disable iff (!rstn)
    !start && !stop && q.st == ST_DEVADR && q.cnt == BYTE_BITS && q.ack
    |=> (q.st == ST_READ) == $past(q.sh[SA_RW]))
    else $error("direction bit not obeyed");

  AST_READ_NACK: assert property (@(posedge scl) disable iff (!rstn)
    !start && !stop && q.st == ST_READ && q.cnt == BYTE_BITS && sda_in
    |=> q.st == ST_IDLE ##1 !sda_oe)
    else $error("kept transmitting after missing acknowledge");

  AST_LATCH_GATE: assert property (@(posedge scl) disable iff (!rstn)
    !start && !stop && q.st == ST_WDATA && q.cnt == 4'h7 && !wel_l &&
    !(q.first && q.base == REG_ADDR)
    |=> !q.ack && $stable(q.pvalid))
    else $error("data accepted with write latch clear");

  AST_PAGE_WRAP: assert property (@(posedge scl) disable iff (!rstn)
    !start && !stop && q.st == ST_WDATA && q.cnt == 4'h7 && wel_l
    |=> q.addr[ADDR_W-1:PAGE_W] == $past(q.addr[ADDR_W-1:PAGE_W]) &&
        q.addr[PAGE_W-1:0] == $past(q.addr[PAGE_W-1:0]) + 5'h01)
    else $error("page address did not wrap in place");

endmodule
`default_nettype wire

// *** dv/sei_master.sv ***
// Two-wire bus master model that drives the serial clock
`timescale 1ns/1ns
`default_nettype none
module sei_master (
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  // Clock stands high between frames; the pull-up holds SDA high
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic start();
    if (scl === 1'b0) begin
      #7 sda_low = 1'b0;
      #8 scl = 1'b1;
    end
    #8 sda_low = 1'b1;
    #8 scl = 1'b0;
  endtask

  task automatic stop();
    #7 sda_low = 1'b1;
    #8 scl = 1'b1;
    #8 sda_low = 1'b0;
    #30;
  endtask

  // Drop the clock after a stop without making a start
  task automatic clock_low();
    #8 scl = 1'b0;
  endtask

  // One clock pulse; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    #7 sda_low = ~b;
    #8 scl = 1'b1;
    #7 s = sda;
    #8 scl = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule
`default_nettype wire

// *** dv/tb_sei_eeprom.sv ***
// Self-checking testbench of the serial EEPROM slave interface
`timescale 1ns/1ns
`default_nettype none
module tb_sei_eeprom;
  import sei_pkg::*;
  // Short write cycle keeps polling quick; still above the page copy
  localparam int unsigned WCYC = 64;
  logic       sys_clk;
  logic       rstn;
  logic       sys_ce;
  logic       wp_pin;
  logic [2:0] strap;
  logic       scl;
  logic       m_low;
  logic       sda_out;
  logic       sda_oe;
  wire  logic sda;
  logic       ack;
  logic       ok;
  logic [10:0] a_lo;
  logic [10:0] a_hi;
  logic [7:0] d_hi;
  logic [7:0] wd [3];
  logic [7:0] rq [2];
  int         n_errors;
  int         n_tests;

  assign sda = ~((sda_oe & ~sda_out) | m_low);

  sei_eeprom #(.WRITE_CYCLES(WCYC)) i_sei_eeprom (
    .sys_clk(sys_clk), .rstn(rstn), .sys_ce(sys_ce), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .select_pin_low(strap[0]), .select_pin_mid_inverted(strap[1]),
    .select_pin_high(strap[2]), .wp_pin(wp_pin));
  sei_master i_sei_master (.scl(scl), .sda_low(m_low), .sda(sda));

  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] own(input logic [2:0] up, input logic rw);
    return {strap[2], ~strap[1], strap[0], up, DEV_TYPE_BIT, rw};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Address polling; no answer means the write cycle still runs
  task automatic poll(input bit busy);
    for (int t = 0; t < 40; t++) begin
      i_sei_master.start();
      i_sei_master.wr_byte(own(3'h0, 1'b0), ack);
      i_sei_master.stop();
      if (t == 0 && busy) chk("busy ack", 8'h00, {7'h0, ack});
      if (ack === 1'b1) return;
    end
    chk("poll", 8'h01, 8'h00);
  endtask

  task automatic wr_frame(input logic [10:0] a, input int n,
                          output logic last);
    i_sei_master.start();
    i_sei_master.wr_byte(own(a[10:8], 1'b0), ack);
    chk("dev ack", 8'h01, {7'h0, ack});
    i_sei_master.wr_byte(a[7:0], ack);
    chk("word ack", 8'h01, {7'h0, ack});
    for (int i = 0; i < n; i++) i_sei_master.wr_byte(wd[i], last);
    i_sei_master.stop();
  endtask

  task automatic wrp(input logic [10:0] a, input logic [7:0] d,
                     input bit busy);
    wd[0] = d;
    wr_frame(a, 1, ok);
    chk("data ack", 8'h01, {7'h0, ok});
    poll(busy);
  endtask

  task automatic rd_frame(input logic [10:0] a, input int n);
    i_sei_master.start();
    i_sei_master.wr_byte(own(a[10:8], 1'b0), ack);
    i_sei_master.wr_byte(a[7:0], ack);
    i_sei_master.start();
    i_sei_master.wr_byte(own(a[10:8], 1'b1), ack);
    chk("read ack", 8'h01, {7'h0, ack});
    for (int i = 0; i < n; i++) i_sei_master.rd_byte(i < n - 1, rq[i]);
    i_sei_master.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Limit is about ten times the expected run length
  initial begin
    #400_000;
    n_errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'h7400_bc15));
    sys_clk = 1'b0;
    rstn    = 1'b0;
    sys_ce  = 1'b1;
    wp_pin  = 1'b0;
    strap   = 3'h0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_frame(REG_ADDR, 1);
    chk("reg reset", PR_CLEAR, rq[0]);
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk) strap <= 3'($urandom);
      #100;
      i_sei_master.start();
      i_sei_master.wr_byte({3'(k), 3'h0, DEV_TYPE_BIT, 1'b0}, ack);
      i_sei_master.stop();
      chk("select ack", {7'h0, 3'(k) == {strap[2], ~strap[1], strap[0]}},
          {7'h0, ack});
    end
    i_sei_master.start();
    repeat (3) i_sei_master.bit_io(1'b0, ack);
    i_sei_master.start();
    i_sei_master.wr_byte(own(3'h0, 1'b0), ack);
    i_sei_master.stop();
    chk("resync ack", 8'h01, {7'h0, ack});
    i_sei_master.start();
    i_sei_master.stop();
    i_sei_master.clock_low();
    i_sei_master.wr_byte(own(3'h0, 1'b0), ack);
    i_sei_master.stop();
    chk("no start ack", 8'h00, {7'h0, ack});
    a_lo  = {1'b0, 5'($urandom), 5'h1e};
    wd[0] = 8'($urandom);
    wr_frame(a_lo, 1, ok);
    chk("no latch ack", 8'h00, {7'h0, ok});
    wrp(REG_ADDR, PR_WEL_VAL, 1'b0);
    rd_frame(REG_ADDR, 1);
    chk("reg latch", 8'h02, rq[0]);
    for (int i = 0; i < 3; i++) wd[i] = 8'($urandom);
    wr_frame(a_lo, 3, ok);
    chk("page ack", 8'h01, {7'h0, ok});
    // Frozen timer keeps the write cycle alive far past its length
    repeat (3) @(posedge sys_clk);
    sys_ce <= 1'b0;
    repeat (200) @(posedge sys_clk);
    sys_ce <= 1'b1;
    poll(1'b1);
    rd_frame(a_lo, 2);
    chk("seq 0", wd[0], rq[0]);
    chk("seq 1", wd[1], rq[1]);
    rd_frame({a_lo[10:5], 5'h00}, 1);
    chk("wrap", wd[2], rq[0]);
    a_hi = {2'b11, 9'($urandom) & 9'h0fe};
    d_hi = 8'($urandom);
    wrp(a_hi, d_hi, 1'b1);
    wrp(REG_ADDR, PR_RWEL_VAL, 1'b0);
    wrp(REG_ADDR, 8'h0a, 1'b1);
    rd_frame(REG_ADDR, 1);
    chk("bp reg", 8'h0a, rq[0]);
    wrp(a_hi, ~d_hi, 1'b1);
    rd_frame(a_hi, 1);
    chk("protected", d_hi, rq[0]);
    wrp(a_lo, ~wd[0], 1'b1);
    rd_frame(a_lo, 1);
    chk("open", wd[0], rq[0]);
    wrp(REG_ADDR, PR_RWEL_VAL, 1'b0);
    wrp(REG_ADDR, 8'h8a, 1'b1);
    @(posedge sys_clk) wp_pin <= 1'b1;
    wrp(REG_ADDR, PR_RWEL_VAL, 1'b0);
    wrp(REG_ADDR, PR_WEL_VAL, 1'b0);
    rd_frame(REG_ADDR, 1);
    chk("locked", 8'h88, rq[0] & 8'h98);
    @(posedge sys_clk) wp_pin <= 1'b0;
    wrp(REG_ADDR, PR_RWEL_VAL, 1'b0);
    wrp(REG_ADDR, PR_WEL_VAL, 1'b1);
    rd_frame(REG_ADDR, 1);
    chk("unlocked", 8'h02, rq[0]);
    test_done();
  end
endmodule
`default_nettype wire
